//--- rtl/analog_io_scaling.sv
// analog input scaling and clamping, analog output scaling, offset and rectify
// assumes converter words arrive on clk_i with their own valid strobes, and
// that loop_tick_i is a one-cycle pulse from the current-loop logic on clk_i
//
// What this block does
// - every input channel multiplies its voltage by a signed gain of -3 to +3, gain 1 maps 10 V to 100 %.
// - every scaled input is held at or below a programmable ceiling of -300 % to +300 %, unless the floor is set above it.
// - every scaled input is held at or above a programmable floor of -300 % to +300 %.
// - there are five input channels and each one's clamped result is readable.
// - every input channel's raw terminal voltage is readable before gain and clamping.
// - the second input channel is sampled on the current-loop tick (about 3.3 ms or 2.6 ms).
// - the second input feeds the second speed setpoint always and the current demand via a switch.
// - every output channel turns a percent demand into a 0 to 10 V converter value.
// - every output channel takes a signed demand of -300 % to +300 %.
// - every output scales by a full-scale percent of -300 % to +300 %, that demand giving 10 V.
// - every output adds an offset of -100 % to +100 % after scaling and before rectifying.
// - with its unipolar bit set an output drives the absolute value, so -10 % gives +1 V.
// - every output channel's driven voltage is readable.
//
// Local design decisions: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
module analog_io_scaling
  import analog_io_pkg::*;
(
  input wire logic clk_i,                              // 40 MHz system clock
  input wire logic rst_i,                              // synchronous reset, active high
  input wire logic wb_cyc_i,                           // wishbone cycle
  input wire logic wb_stb_i,                           // wishbone strobe
  input wire logic wb_we_i,                            // wishbone write enable
  input wire logic [7:0] wb_adr_i,                     // wishbone byte address
  input wire logic [31:0] wb_dat_i,                    // wishbone write data
  input wire logic [3:0] wb_sel_i,                     // wishbone byte selects
  output logic [31:0] wb_dat_o,                        // wishbone read data
  output logic wb_ack_o,                               // wishbone acknowledge
  input wire fix_t [NUM_IN-1:0] adc_volt_i,            // converter words, mV signed
  input wire logic [NUM_IN-1:0] adc_valid_i,           // converter word valid pulses
  input wire logic loop_tick_i,                        // current-loop update pulse
  output fix_t second_speed_setpoint_o,                // fast input result, 0.01 %
  output fix_t current_demand_o,                       // fast input via switch, 0.01 %
  output dac_code_t [NUM_OUT-1:0] dac_code_o           // output converter codes, mV
);

  // limit a value to a closed range; lo wins if the limits cross
  // the compare runs at 32 bits so that a product or a merged word that
  // overflows 16 bits is caught before it is cut down
  function automatic fix_t sat16(input logic signed [31:0] v, input fix_t lo, input fix_t hi);
    fix_t r;
    r = v[15:0];
    if (v > 32'(hi)) begin
      r = hi;
    end
    if (v < 32'(lo)) begin
      r = lo;
    end
    return r;
  endfunction

  // merge the low two byte lanes of a write into a stored value
  function automatic fix_t merge16(input fix_t old, input logic [15:0] d, input logic [1:0] sel);
    fix_t r;
    r = old;
    if (sel[0]) begin
      r[7:0] = d[7:0];
    end
    if (sel[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  // settings as software last wrote them, always inside their legal range,
  // so the datapath never has to guard against an out-of-range gain or limit
  in_cfg_s [NUM_IN-1:0] in_cfg_reg;
  out_cfg_s [NUM_OUT-1:0] out_cfg_reg;
  logic [CTRL_WIDTH-1:0] ctrl_reg;
  fix_t [NUM_IN-1:0] raw_reg;
  fix_t [NUM_IN-1:0] result_reg;
  dac_code_t [NUM_OUT-1:0] volt_reg;
  fix_t setpoint_reg;
  fix_t demand_reg;

  // bus side state; read data is registered so that the wide read mux
  // never sits between the address pins and the data pins
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic bus_req;
  logic wr_req;
  logic [2:0] region;
  logic [2:0] in_field;
  logic [1:0] out_field;
  logic out_ch;

  // request decode; a new request is taken only while no ack is standing
  // limitation: the ack cycle never takes a request, so back-to-back strobes are served
  // one every two cycles; the master need not drop its strobe between them
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr_req = bus_req && wb_we_i;
  assign region = wb_adr_i[7:5];
  assign in_field = wb_adr_i[4:2];
  assign out_field = wb_adr_i[3:2];
  assign out_ch = wb_adr_i[4];

  // ack one cycle after the strobe, dropped the next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req;
    end
  end

  // control word: current demand switch and unipolar bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr_req && region == REGION_CTRL && in_field == IN_F_GAIN && wb_sel_i[0]) begin
      ctrl_reg <= wb_dat_i[CTRL_WIDTH-1:0];
    end
  end

  // input channel settings; written values are held inside their legal range
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int k = 0; k < NUM_IN; k++) begin
        in_cfg_reg[k] <= IN_CFG_RST;
      end
    end else if (wr_req) begin
      for (int k = 0; k < NUM_IN; k++) begin
        if (region == REGION_IN_FIRST + 3'(k)) begin
          case (in_field)
            IN_F_GAIN: begin
              in_cfg_reg[k].gain <= sat16(32'(merge16(in_cfg_reg[k].gain, wb_dat_i[15:0],
                                    wb_sel_i[1:0])), GAIN_LO, GAIN_HI);
            end
            IN_F_MAX: begin
              in_cfg_reg[k].max_pct <= sat16(32'(merge16(in_cfg_reg[k].max_pct,
                                       wb_dat_i[15:0], wb_sel_i[1:0])), PCT_LO, PCT_HI);
            end
            IN_F_MIN: begin
              in_cfg_reg[k].min_pct <= sat16(32'(merge16(in_cfg_reg[k].min_pct,
                                       wb_dat_i[15:0], wb_sel_i[1:0])), PCT_LO, PCT_HI);
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // output channel settings, each held inside its legal range
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int j = 0; j < NUM_OUT; j++) begin
        out_cfg_reg[j] <= OUT_CFG_RST;
      end
    end else if (wr_req && region == REGION_OUT) begin
      for (int j = 0; j < NUM_OUT; j++) begin
        if (out_ch == 1'(j)) begin
          case (out_field)
            OUT_F_DEMAND: begin
              out_cfg_reg[j].demand <= sat16(32'(merge16(out_cfg_reg[j].demand,
                                      wb_dat_i[15:0], wb_sel_i[1:0])), PCT_LO, PCT_HI);
            end
            OUT_F_FULL: begin
              out_cfg_reg[j].full_scale <= sat16(32'(merge16(out_cfg_reg[j].full_scale,
                                          wb_dat_i[15:0], wb_sel_i[1:0])), PCT_LO, PCT_HI);
            end
            OUT_F_OFFSET: begin
              out_cfg_reg[j].offset <= sat16(32'(merge16(out_cfg_reg[j].offset,
                                      wb_dat_i[15:0], wb_sel_i[1:0])), OFS_LO, OFS_HI);
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // per input channel: capture, gain, clamp
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_in
      logic take;
      logic signed [31:0] prod;
      logic signed [31:0] scaled;
      fix_t clamped;

      // the fast channel ignores its valid strobe and samples on the loop tick
      if (gi == FAST_CH) begin : g_fast
        assign take = loop_tick_i;
      end else begin : g_slow
        assign take = adc_valid_i[gi];
      end

      // mV times 0.0001 steps over 10000 gives 0.01 %: 10 V at gain 1 is 100.00 %
      // the divide truncates toward zero, so a small negative product reads
      // as zero rather than as minus one step; the product fits 32 bits
      // because both factors are held to 16 signed bits
      assign prod = 32'(raw_reg[gi]) * 32'(in_cfg_reg[gi].gain);
      assign scaled = prod / GAIN_ONE_W;

      // ceiling first, then floor, so a crossed pair settles on the floor
      always_comb begin
        clamped = scaled[15:0];
        if (scaled > 32'(in_cfg_reg[gi].max_pct)) begin
          clamped = in_cfg_reg[gi].max_pct;
        end
        if (scaled < 32'(in_cfg_reg[gi].min_pct)) begin
          clamped = in_cfg_reg[gi].min_pct;
        end
      end

      // raw word kept as measured, before any gain
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          raw_reg[gi] <= FIX_ZERO;
        end else if (take) begin
          raw_reg[gi] <= adc_volt_i[gi];
        end
      end

      // registered result keeps the long multiply and divide off the bus path
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          result_reg[gi] <= FIX_ZERO;
        end else begin
          result_reg[gi] <= clamped;
        end
      end
    end
  endgenerate

  // fast channel routing: setpoint always, current demand only with the switch closed
  // the switch resets open, so a fresh part never lets the fast input reach
  // the current demand until software asks for it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      setpoint_reg <= FIX_ZERO;
      demand_reg <= FIX_ZERO;
    end else begin
      setpoint_reg <= result_reg[FAST_CH];
      demand_reg <= ctrl_reg[CTRL_SWITCH_BIT] ? result_reg[FAST_CH] : FIX_ZERO;
    end
  end

  // per output channel: scale, offset, optional rectify, saturate
  // the whole chain is combinational from the settings and lands in one
  // register, so a settings write shows on the converter one edge later;
  // trade-off: one long divide path in exchange for no extra latency
  genvar go;
  generate
    for (go = 0; go < NUM_OUT; go++) begin : g_out
      logic signed [31:0] scaled_mv;
      logic signed [31:0] shifted_mv;
      logic signed [31:0] rect_mv;
      logic unipolar;

      assign unipolar = ctrl_reg[CTRL_UNIPOLAR_LSB + go];

      // a demand equal to the full-scale percent gives 10000 mV; zero full scale gives 0 V
      always_comb begin
        scaled_mv = ZERO_W;
        if (out_cfg_reg[go].full_scale != FIX_ZERO) begin
          scaled_mv = (32'(out_cfg_reg[go].demand) * FULL_SCALE_MV)
                      / 32'(out_cfg_reg[go].full_scale);
        end
      end

      // 0.01 % of 10 V is 1 mV, so the offset adds straight in
      assign shifted_mv = scaled_mv + 32'(out_cfg_reg[go].offset);

      // rectify after the offset
      assign rect_mv = (unipolar && shifted_mv < ZERO_W) ? -shifted_mv : shifted_mv;

      // clip instead of wrap: a negative bipolar value drives 0 V
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          volt_reg[go] <= '0;
        end else if (rect_mv > FULL_SCALE_MV) begin
          volt_reg[go] <= FULL_SCALE_MV[13:0];
        end else if (rect_mv < ZERO_W) begin
          volt_reg[go] <= '0;
        end else begin
          volt_reg[go] <= rect_mv[13:0];
        end
      end
    end
  endgenerate

  // read mux; unmapped words read as zero and are still acknowledged
  // acking every address keeps a stray access from hanging the bus master
  always_comb begin
    rdata_next = ZERO_W;
    case (region)
      REGION_CTRL: begin
        if (in_field == IN_F_GAIN) begin
          rdata_next = 32'(ctrl_reg);
        end
      end
      REGION_OUT: begin
        case (out_field)
          OUT_F_DEMAND: rdata_next = {READ_PAD, out_cfg_reg[out_ch].demand};
          OUT_F_FULL: rdata_next = {READ_PAD, out_cfg_reg[out_ch].full_scale};
          OUT_F_OFFSET: rdata_next = {READ_PAD, out_cfg_reg[out_ch].offset};
          OUT_F_VOLT: rdata_next = 32'(volt_reg[out_ch]);
          default: rdata_next = ZERO_W;
        endcase
      end
      default: begin
        for (int k = 0; k < NUM_IN; k++) begin
          if (region == REGION_IN_FIRST + 3'(k)) begin
            case (in_field)
              IN_F_GAIN: rdata_next = {READ_PAD, in_cfg_reg[k].gain};
              IN_F_MAX: rdata_next = {READ_PAD, in_cfg_reg[k].max_pct};
              IN_F_MIN: rdata_next = {READ_PAD, in_cfg_reg[k].min_pct};
              IN_F_RAW: rdata_next = {READ_PAD, raw_reg[k]};
              IN_F_RESULT: rdata_next = {READ_PAD, result_reg[k]};
              default: rdata_next = ZERO_W;
            endcase
          end
        end
      end
    endcase
  end

  // read data is captured with the ack and held until the next read request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= ZERO_W;
    end else if (bus_req && !wb_we_i) begin
      rdata_reg <= rdata_next;
    end
  end

  // every output is a plain register copy, so nothing combinational reaches a pin
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign second_speed_setpoint_o = setpoint_reg;
  assign current_demand_o = demand_reg;
  assign dac_code_o = volt_reg;

endmodule

//--- shared/analog_io_pkg.sv
// constants, field layouts and carrier types for the analog i/o scaling block
// assumes a 32-bit classic wishbone register bus and a single 40 MHz clock
package analog_io_pkg;

  // channel counts and the channel that follows the current-loop tick
  localparam int NUM_IN = 5;
  localparam int NUM_OUT = 2;
  localparam int FAST_CH = 1;

  // fixed point: gain in 0.0001 steps, percent in 0.01 % steps, volts in mV
  typedef logic signed [15:0] fix_t;
  typedef logic [13:0] dac_code_t;

  localparam fix_t GAIN_ONE = 16'h2710;        // 1.0000
  localparam fix_t GAIN_HI = 16'h7530;         // +3.0000
  localparam fix_t GAIN_LO = 16'h8AD0;         // -3.0000
  localparam fix_t PCT_HI = 16'h7530;          // +300.00 %
  localparam fix_t PCT_LO = 16'h8AD0;          // -300.00 %
  localparam fix_t OFS_HI = 16'h2710;          // +100.00 %
  localparam fix_t OFS_LO = 16'hD8F0;          // -100.00 %
  localparam fix_t PCT_FULL = 16'h2710;        // 100.00 %
  localparam fix_t FIX_ZERO = 16'h0000;
  localparam logic signed [31:0] GAIN_ONE_W = 32'h0000_2710;
  localparam logic signed [31:0] FULL_SCALE_MV = 32'h0000_2710;  // 10 V in mV
  localparam logic signed [31:0] ZERO_W = 32'h0000_0000;
  localparam logic [15:0] READ_PAD = 16'h0000;

  // register map: adr[7:5] region, adr[4:2] field; in the output region adr[4] channel, adr[3:2] field
  localparam logic [2:0] REGION_CTRL = 3'h0;
  localparam logic [2:0] REGION_IN_FIRST = 3'h1;
  localparam logic [2:0] REGION_OUT = 3'h6;
  localparam logic [2:0] IN_F_GAIN = 3'h0;
  localparam logic [2:0] IN_F_MAX = 3'h1;
  localparam logic [2:0] IN_F_MIN = 3'h2;
  localparam logic [2:0] IN_F_RAW = 3'h3;
  localparam logic [2:0] IN_F_RESULT = 3'h4;
  localparam logic [1:0] OUT_F_DEMAND = 2'h0;
  localparam logic [1:0] OUT_F_FULL = 2'h1;
  localparam logic [1:0] OUT_F_OFFSET = 2'h2;
  localparam logic [1:0] OUT_F_VOLT = 2'h3;

  // control word: bit 0 current demand switch, bits 2:1 unipolar per output
  localparam int CTRL_SWITCH_BIT = 0;
  localparam int CTRL_UNIPOLAR_LSB = 1;
  localparam int CTRL_WIDTH = 3;
  localparam logic [2:0] CTRL_RST = 3'h0;

  typedef struct packed {
    fix_t gain;
    fix_t max_pct;
    fix_t min_pct;
  } in_cfg_s;

  typedef struct packed {
    fix_t demand;
    fix_t full_scale;
    fix_t offset;
  } out_cfg_s;

  localparam in_cfg_s IN_CFG_RST = '{gain: GAIN_ONE, max_pct: PCT_HI, min_pct: PCT_LO};
  localparam out_cfg_s OUT_CFG_RST = '{demand: FIX_ZERO, full_scale: PCT_FULL,
                                       offset: FIX_ZERO};

endpackage

//--- verification/analog_io_scaling_properties.sv
// port assertions for the analog scaling block, bound into every instance
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/1ps
module analog_io_scaling_properties
  import analog_io_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_we_i, // bus write
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // acknowledge
  input wire logic loop_tick_i, // current-loop tick
  input wire fix_t second_speed_setpoint_o, // fast input result
  input wire fix_t current_demand_o, // switched fast input
  input wire dac_code_t [NUM_OUT-1:0] dac_code_o // converter codes
);
  logic [2:0] quiet_reg;

  // edges since the last tick or taken write; results may only move shortly after one
  always_ff @(posedge clk_i) begin
    if (rst_i || loop_tick_i || (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o)) begin
      quiet_reg <= 3'h0;
    end else if (quiet_reg != 3'h7) begin
      quiet_reg <= quiet_reg + 3'h1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack stood longer than one cycle");
  ack_on_request_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not acknowledged one cycle later");
  ack_has_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  read_pad_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  dac_one_range_a: assert property (dac_code_o[0] <= 14'h2710)
    else $error("first code above ten volts");
  dac_two_range_a: assert property (dac_code_o[1] <= 14'h2710)
    else $error("second code above ten volts");
  demand_switch_a: assert property (current_demand_o == 16'h0000 ||
    current_demand_o == second_speed_setpoint_o)
    else $error("current demand not fed from the fast input");
  fast_quiet_a: assert property (quiet_reg >= 3'h4 |-> $stable(second_speed_setpoint_o))
    else $error("setpoint moved without a tick");
  dac_quiet_a: assert property (quiet_reg >= 3'h2 |-> $stable(dac_code_o))
    else $error("codes moved without a write");

  write_seen_c: cover property (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o);
  tick_seen_c: cover property (loop_tick_i);
  full_code_c: cover property (dac_code_o[0] == 14'h2710);
endmodule

bind analog_io_scaling analog_io_scaling_properties u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .loop_tick_i(loop_tick_i),
  .second_speed_setpoint_o(second_speed_setpoint_o), .current_demand_o(current_demand_o),
  .dac_code_o(dac_code_o)
);

//--- verification/analog_io_scaling_tb.sv
// self-checking bench for the analog scaling block over classic wishbone
// assumes the converter stand-in model and the bound port checker
`timescale 1ns/1ps
module analog_io_scaling_tb
  import analog_io_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  fix_t [NUM_IN-1:0] adc_volt;
  logic [NUM_IN-1:0] adc_valid;
  logic loop_tick;
  fix_t setpoint;
  fix_t demand;
  dac_code_t [NUM_OUT-1:0] dac_code;
  int err_total = 0;
  int comparisons = 0;

  // 40 MHz
  always #12.5 clk_i = ~clk_i;

  analog_io_scaling u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .adc_volt_i(adc_volt),
    .adc_valid_i(adc_valid), .loop_tick_i(loop_tick), .second_speed_setpoint_o(setpoint),
    .current_demand_o(demand), .dac_code_o(dac_code));
  converter_model u_conv (.clk_i(clk_i), .adc_volt_o(adc_volt), .adc_valid_o(adc_valid),
    .loop_tick_o(loop_tick));

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input fix_t exp, input fix_t got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // one classic cycle; the request stands until ack is sampled high at an edge
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] d,
                         output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (n >= 20) begin
      err_total++;
      $display("MISMATCH ack expected 1 seen timeout");
      give_verdict();
    end
  endtask

  task automatic wb_wr(input logic [7:0] adr, input logic [31:0] d);
    logic [31:0] rd;
    wb_xfer(1'b1, adr, d, rd);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] adr, input fix_t exp);
    logic [31:0] rd;
    wb_xfer(1'b0, adr, 32'h0000_0000, rd);
    chk(what, exp, rd[15:0]);
  endtask

  function automatic logic [7:0] in_adr(input int k, input int f);
    return 8'(32'h20 + 32'h20 * k + 32'h4 * f);
  endfunction

  function automatic logic [7:0] out_adr(input int j, input int f);
    return 8'(32'hC0 + 32'h10 * j + 32'h4 * f);
  endfunction

  // int division truncates toward zero; floor applied last so it wins
  function automatic int exp_in(input int mv, input int g, input int lo, input int hi);
    int v;
    v = (mv * g) / GAIN_ONE_W;
    if (v > hi) v = hi;
    if (v < lo) v = lo;
    return v;
  endfunction

  function automatic int exp_out(input int dm, input int fs, input int ofs, input int uni);
    int v;
    v = (fs == 0) ? 0 : (dm * FULL_SCALE_MV) / fs;
    v = v + ofs;
    if (uni != 0 && v < 0) v = -v;
    if (v < 0) v = 0;
    if (v > FULL_SCALE_MV) v = FULL_SCALE_MV;
    return v;
  endfunction

  initial begin
    int g[5] = '{10000, 0, -30000, 30000, 5000};
    int mv[5] = '{5000, 0, 2500, 10000, -4000};
    int hi[5] = '{30000, 0, 30000, 2000, 30000};
    int lo[5] = '{-30000, 0, -30000, -30000, 500};
    int dm[8] = '{5000, 5000, -1000, -1000, 30000, 2000, -30000, 0};
    int fs[8] = '{10000, 5000, 10000, 10000, 10000, 10000, -30000, 10000};
    int ofs[8] = '{0, 0, 0, 0, 0, 1000, -10000, -2000};
    int uni[8] = '{0, 0, 1, 0, 0, 0, 0, 1};
    int e;
    int j;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("gain_rst", in_adr(4, 0), GAIN_ONE);
    rd_chk("max_rst", in_adr(4, 1), PCT_HI);
    rd_chk("min_rst", in_adr(4, 2), PCT_LO);
    rd_chk("full_rst", out_adr(1, 1), PCT_FULL);
    rd_chk("unmapped", 8'hFC, FIX_ZERO);
    $display("test reset_values done");
    // slow channels: gain extremes, ceiling and floor
    for (int k = 0; k < NUM_IN; k++) begin
      if (k == FAST_CH) continue;
      wb_wr(in_adr(k, 0), g[k]);
      wb_wr(in_adr(k, 1), hi[k]);
      wb_wr(in_adr(k, 2), lo[k]);
      u_conv.sample(k, fix_t'(mv[k]), 1'b0);
      repeat (3) @(posedge clk_i);
      rd_chk("raw", in_adr(k, 3), fix_t'(mv[k]));
      rd_chk("result", in_adr(k, 4), fix_t'(exp_in(mv[k], g[k], lo[k], hi[k])));
    end
    $display("test input_scaling done");
    // fast channel: a plain strobe is ignored, only the tick captures
    u_conv.sample(FAST_CH, fix_t'(4000), 1'b0);
    repeat (4) @(posedge clk_i);
    rd_chk("fast_raw_idle", in_adr(FAST_CH, 3), FIX_ZERO);
    u_conv.sample(FAST_CH, fix_t'(4000), 1'b1);
    repeat (4) @(posedge clk_i);
    chk("setpoint", fix_t'(4000), setpoint);
    chk("demand_open", FIX_ZERO, demand);
    wb_wr(8'h00, 32'h0000_0001);
    repeat (3) @(posedge clk_i);
    chk("demand_closed", fix_t'(4000), demand);
    wb_wr(8'h00, 32'h0000_0000);
    repeat (3) @(posedge clk_i);
    chk("demand_isolated", FIX_ZERO, demand);
    $display("test fast_channel done");
    // output channels: scaling, offset, rectifying and saturation
    for (int i = 0; i < 8; i++) begin
      j = i % 2;
      wb_wr(8'h00, 32'(uni[i]) << (CTRL_UNIPOLAR_LSB + j));
      wb_wr(out_adr(j, 1), fs[i]);
      wb_wr(out_adr(j, 2), ofs[i]);
      wb_wr(out_adr(j, 0), dm[i]);
      @(posedge clk_i);
      e = exp_out(dm[i], fs[i], ofs[i], uni[i]);
      chk("dac_code", fix_t'(e), fix_t'({2'b00, dac_code[j]}));
      rd_chk("dac_volt", out_adr(j, 3), fix_t'(e));
    end
    $display("test output_scaling done");
    give_verdict();
  end
endmodule

//--- verification/converter_model.sv
// stand-in for the converter channels: input words, their strobes and the loop tick
// assumes the bench calls sample() from one thread at a time
`timescale 1ns/1ps
module converter_model
  import analog_io_pkg::*;
(
  input wire logic clk_i, // system clock
  output fix_t [NUM_IN-1:0] adc_volt_o, // converter words, mV
  output logic [NUM_IN-1:0] adc_valid_o, // word strobes
  output logic loop_tick_o // current-loop tick
);
  initial begin
    adc_volt_o = '0;
    adc_valid_o = '0;
    loop_tick_o = 1'b0;
  end

  // one word per call; the tick argument picks the loop tick or the channel's own strobe, for any channel
  task automatic sample(input int ch, input fix_t mv, input logic tick);
    @(posedge clk_i);
    adc_volt_o[ch] <= mv;
    if (tick) loop_tick_o <= 1'b1;
    else adc_valid_o[ch] <= 1'b1;
    @(posedge clk_i);
    adc_valid_o <= '0;
    loop_tick_o <= 1'b0;
    adc_volt_o[ch] <= ~mv; // word is stale once the strobe drops, so never show it again
  endtask
endmodule
